// ---- core/cie_clear_exec.sv ----
// clear-instruction executor: four-phase sequencer, flags, watchdog and APB registers
//
// How it works
// - file clear writes zero, sets zero flag
// - accumulator clear zeroes W, sets zero flag
// - watchdog refresh opcode zeroes watchdog counter
// - refresh also zeroes the watchdog prescaler
// - refresh sets both status flags, others kept
//
// Added by the designer: the register offsets and the APB interface to the registers.
`default_nettype none
module cie_clear_exec #(
	parameter int unsigned WDOG_W = 8,
	parameter int unsigned PS_W   = 8
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [11:0]         paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [13:0]         instr_word,
	input  wire logic                instr_valid,
	input  wire logic                sleep_entry,
	output cie_pkg::cie_phase_e      phase,
	output logic                     file_we,
	output logic [6:0]               file_addr,
	output logic [7:0]               file_wdata,
	output logic [7:0]               working_register,
	output logic                     zero_flag,
	output logic                     timeout_flag_n,
	output logic                     powerdown_flag_n,
	output logic [WDOG_W-1:0]        watchdog_counter,
	output logic [PS_W-1:0]          watchdog_prescale,
	output logic                     watchdog_timeout
);
	cie_pkg::cie_phase_e     phase_q;
	cie_pkg::cie_phase_e     phase_d;
	cie_pkg::cie_dec_s       dec_now;
	cie_pkg::cie_dec_s       dec_q;
	logic [7:0]              wreg_q;
	logic                    zero_q;
	logic                    to_n_q;
	logic                    pd_n_q;
	logic [3:0]              ctrl_q;
	logic [15:0]             execs_q;
	logic [31:0]             prdata_q;
	logic                    err_q;
	logic [31:0]             rdata_d;
	logic                    apb_setup;
	logic                    apb_write;
	logic                    exec_now;
	logic                    clear_file_register_op;
	logic                    clear_accumulator_op;
	logic                    watchdog_refresh_op;

	// true for the offsets that the register file answers
	function automatic logic is_mapped(input logic [11:0] addr);
		return (addr == cie_pkg::ADDR_CTRL) || (addr == cie_pkg::ADDR_STATUS) ||
			(addr == cie_pkg::ADDR_WREG) || (addr == cie_pkg::ADDR_WDOG) ||
			(addr == cie_pkg::ADDR_EXECS);
	endfunction

	cie_decoder u_decoder (
		.instr_word (instr_word),
		.dec        (dec_now)
	);

	// the phase counter free-runs; the core aligns its fetch to the first phase
	always_comb begin
		unique case (phase_q)
			cie_pkg::CIE_Q1: phase_d = cie_pkg::CIE_Q2;
			cie_pkg::CIE_Q2: phase_d = cie_pkg::CIE_Q3;
			cie_pkg::CIE_Q3: phase_d = cie_pkg::CIE_Q4;
			cie_pkg::CIE_Q4: phase_d = cie_pkg::CIE_Q1;
		endcase
	end

	// phase register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= cie_pkg::CIE_Q1;
		end else begin
			phase_q <= phase_d;
		end
	end

	// decode is latched in the first phase only; a word offered later is taken only if still valid in the next Q1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_q <= '{op: cie_pkg::CIE_OP_NONE, faddr: 7'h00};
		end else if (phase_q == cie_pkg::CIE_Q1) begin
			if (instr_valid) begin
				dec_q <= dec_now;
			end else begin
				dec_q <= '{op: cie_pkg::CIE_OP_NONE, faddr: 7'h00};
			end
		end
	end

	// execute strobes, all confined to the fourth phase
	assign exec_now               = (phase_q == cie_pkg::CIE_Q4);
	assign clear_file_register_op = exec_now && (dec_q.op == cie_pkg::CIE_OP_FILE);
	assign clear_accumulator_op   = exec_now && (dec_q.op == cie_pkg::CIE_OP_ACC);
	assign watchdog_refresh_op    = exec_now && (dec_q.op == cie_pkg::CIE_OP_WDOG);

	// register-file write port; address holds the whole cycle
	assign file_we    = clear_file_register_op;
	assign file_addr  = dec_q.faddr;
	assign file_wdata = cie_pkg::CLEAR_VALUE;

	// working register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wreg_q <= cie_pkg::WREG_RESET;
		end else if (clear_accumulator_op) begin
			wreg_q <= cie_pkg::CLEAR_VALUE;
		end
	end

	// zero flag: only the two data clears touch it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_q <= cie_pkg::ZERO_RESET;
		end else if (clear_file_register_op || clear_accumulator_op) begin
			zero_q <= 1'b1;
		end
	end

	// timeout flag: refresh sets it, a watchdog overflow clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_n_q <= cie_pkg::TO_N_RESET;
		end else if (watchdog_refresh_op) begin
			to_n_q <= 1'b1;
		end else if (watchdog_timeout) begin
			to_n_q <= 1'b0;
		end
	end

	// power-down flag: the refresh wins over a sleep entry in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_n_q <= cie_pkg::PD_N_RESET;
		end else if (watchdog_refresh_op) begin
			pd_n_q <= 1'b1;
		end else if (sleep_entry) begin
			pd_n_q <= 1'b0;
		end
	end

	cie_watchdog #(
		.CNT_W (WDOG_W),
		.PS_W  (PS_W)
	) u_watchdog (
		.pclk       (pclk),
		.presetn    (presetn),
		.enable     (ctrl_q[cie_pkg::CTRL_WDOG_EN]),
		.ps_sel     (ctrl_q[cie_pkg::CTRL_PS_LSB +: cie_pkg::CTRL_PS_W]),
		.clear      (watchdog_refresh_op),
		.count_q    (watchdog_counter),
		.prescale_q (watchdog_prescale),
		.timeout_q  (watchdog_timeout)
	);

	// count of executed clear operations, wraps silently
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			execs_q <= '0;
		end else if (exec_now && (dec_q.op != cie_pkg::CIE_OP_NONE)) begin
			execs_q <= execs_q + 16'h0001;
		end
	end

	assign phase            = phase_q;
	assign working_register = wreg_q;
	assign zero_flag        = zero_q;
	assign timeout_flag_n   = to_n_q;
	assign powerdown_flag_n = pd_n_q;

	// apb phases
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (paddr)
			cie_pkg::ADDR_CTRL:   rdata_d = {28'h000_0000, ctrl_q};
			cie_pkg::ADDR_STATUS: rdata_d = {28'h000_0000, dec_q.op != cie_pkg::CIE_OP_NONE,
				to_n_q, pd_n_q, zero_q};
			cie_pkg::ADDR_WREG:   rdata_d = {24'h00_0000, wreg_q};
			cie_pkg::ADDR_WDOG:   rdata_d = 32'(watchdog_counter);
			cie_pkg::ADDR_EXECS:  rdata_d = {16'h0000, execs_q};
			default:              rdata_d = 32'h0000_0000;
		endcase
	end

	// read data and error are captured in the setup cycle so prdata is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end else if (apb_setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
			err_q    <= !is_mapped(paddr);
		end
	end

	// control register; writes elsewhere are ignored, read-only ones without error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= cie_pkg::CTRL_RESET;
		end else if (apb_write && (paddr == cie_pkg::ADDR_CTRL) && pstrb[0]) begin
			ctrl_q <= pwdata[3:0];
		end
	end

	// zero-wait-state slave
	assign pready  = psel && penable;
	assign pslverr = psel && penable && err_q;
	assign prdata  = prdata_q;

	// helper: tracks whether the watched clear has just executed
	logic exec_file_q;
	logic exec_acc_q;
	logic exec_wdog_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_file_q <= 1'b0;
			exec_acc_q  <= 1'b0;
			exec_wdog_q <= 1'b0;
		end else begin
			exec_file_q <= clear_file_register_op;
			exec_acc_q  <= clear_accumulator_op;
			exec_wdog_q <= watchdog_refresh_op;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_four_phases;
		(phase == cie_pkg::CIE_Q1) ##1 (phase == cie_pkg::CIE_Q2) ##1
		(phase == cie_pkg::CIE_Q3) ##1 (phase == cie_pkg::CIE_Q4);
	endsequence

	sequence s_take_file;
		(phase == cie_pkg::CIE_Q1) && instr_valid &&
		(instr_word[13:7] == cie_pkg::OPC_CLEAR_FILE);
	endsequence

	a_file_clear_write: assert property (s_take_file |-> ##3 (file_we &&
		file_wdata == 8'h00 && file_addr == $past(instr_word[6:0], 3)) ##1 zero_flag)
		else $error("file clear did not write zero and set zero flag");

	a_acc_clear_ignores: assert property ((phase == cie_pkg::CIE_Q1) && instr_valid &&
		(instr_word[13:7] == cie_pkg::OPC_CLEAR_ACC) |-> !file_we[*4] ##1
		(working_register == 8'h00 && zero_flag))
		else $error("accumulator clear missed or wrote file");

	a_wdog_count_zero: assert property (exec_wdog_q |-> watchdog_counter == '0)
		else $error("watchdog counter not zero after refresh");

	a_wdog_ps_zero: assert property (exec_wdog_q |-> watchdog_prescale == '0 &&
		!watchdog_timeout)
		else $error("prescaler not zero after refresh");

	a_refresh_flags: assert property (watchdog_refresh_op |=> timeout_flag_n &&
		powerdown_flag_n && $stable(zero_flag) && $stable(working_register))
		else $error("refresh flags wrong or other state disturbed");

	a_phase_order: assert property ((phase == cie_pkg::CIE_Q1) |-> s_four_phases)
		else $error("phases out of order");

	a_write_fourth: assert property (file_we |-> phase == cie_pkg::CIE_Q4 &&
		$past(phase, 3) == cie_pkg::CIE_Q1)
		else $error("file write outside fourth phase");

	a_zero_kept: assert property (!exec_file_q && !exec_acc_q |-> $stable(zero_flag))
		else $error("zero flag changed without a data clear");

	// an overflow pulls the timeout flag low unless a refresh lands in the same cycle
	a_timeout_flag: assert property (watchdog_timeout && !watchdog_refresh_op |=>
		!timeout_flag_n)
		else $error("timeout pulse did not clear the timeout flag");

	// sleep entry pulls the power-down flag low unless a refresh lands with it
	a_sleep_flag: assert property (sleep_entry && !watchdog_refresh_op |=>
		!powerdown_flag_n)
		else $error("sleep entry did not clear the power-down flag");

	a_apb_answer: assert property (psel && !penable ##1 psel && penable |->
		pready && (pslverr == !is_mapped($past(paddr))))
		else $error("apb access not answered in one cycle");
endmodule
`default_nettype wire

// ---- core/cie_pkg.sv ----
// shared constants, types and carriers of the clear-instruction executor
`default_nettype none
package cie_pkg;
	// word widths of the core
	localparam int unsigned INSTR_W = 14;
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned FADDR_W = 7;
	localparam int unsigned APB_AW  = 12;

	// opcode fields: bits 13:7 select the clear-file and clear-accumulator forms
	localparam logic [6:0]  OPC_CLEAR_FILE  = 7'h03;
	localparam logic [6:0]  OPC_CLEAR_ACC   = 7'h02;
	localparam logic [13:0] OPC_WDOG_REFRESH = 14'h0064;
	localparam logic [7:0]  CLEAR_VALUE     = 8'h00;

	// register byte addresses
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_WREG   = 12'h008;
	localparam logic [11:0] ADDR_WDOG   = 12'h00C;
	localparam logic [11:0] ADDR_EXECS  = 12'h010;

	// control fields
	localparam int unsigned CTRL_W          = 4;
	localparam int unsigned CTRL_WDOG_EN    = 0;
	localparam int unsigned CTRL_PS_LSB     = 1;
	localparam int unsigned CTRL_PS_W       = 3;
	localparam logic [3:0]  CTRL_RESET      = 4'h0;

	// status fields
	localparam int unsigned ST_ZERO  = 0;
	localparam int unsigned ST_PD_N  = 1;
	localparam int unsigned ST_TO_N  = 2;
	localparam int unsigned ST_BUSY  = 3;

	// reset values of the flags and working register
	localparam logic        ZERO_RESET = 1'b0;
	localparam logic        TO_N_RESET = 1'b1;
	localparam logic        PD_N_RESET = 1'b1;
	localparam logic [7:0]  WREG_RESET = 8'h00;
	localparam int unsigned EXECS_W    = 16;

	// decoded operation
	typedef enum logic [1:0] {
		CIE_OP_NONE = 2'b00,
		CIE_OP_FILE = 2'b01,
		CIE_OP_ACC  = 2'b10,
		CIE_OP_WDOG = 2'b11
	} cie_op_e;

	// four phases of one instruction cycle
	typedef enum logic [1:0] {
		CIE_Q1 = 2'b00,
		CIE_Q2 = 2'b01,
		CIE_Q3 = 2'b10,
		CIE_Q4 = 2'b11
	} cie_phase_e;

	// decoder result carried through the instruction cycle
	typedef struct packed {
		cie_op_e            op;
		logic [6:0]         faddr;
	} cie_dec_s;
endpackage
`default_nettype wire

// ---- core/cie_decoder.sv ----
// combinational decoder for the three clear instructions
`default_nettype none
module cie_decoder (
	input  wire logic [13:0]      instr_word,
	output cie_pkg::cie_dec_s     dec
);
	// the accumulator form ignores its low seven bits entirely
	always_comb begin
		dec.faddr = instr_word[6:0];
		if (instr_word[13:7] == cie_pkg::OPC_CLEAR_FILE) begin
			dec.op = cie_pkg::CIE_OP_FILE;
		end else if (instr_word[13:7] == cie_pkg::OPC_CLEAR_ACC) begin
			dec.op = cie_pkg::CIE_OP_ACC;
		end else if (instr_word == cie_pkg::OPC_WDOG_REFRESH) begin
			dec.op = cie_pkg::CIE_OP_WDOG;
		end else begin
			dec.op = cie_pkg::CIE_OP_NONE;
		end
	end
endmodule
`default_nettype wire

// ---- core/cie_watchdog.sv ----
// watchdog counter with its prescaler, cleared by the refresh operation
`default_nettype none
module cie_watchdog #(
	parameter int unsigned CNT_W = 8,
	parameter int unsigned PS_W  = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             enable,
	input  wire logic [2:0]       ps_sel,
	input  wire logic             clear,
	output logic [CNT_W-1:0]      count_q,
	output logic [PS_W-1:0]       prescale_q,
	output logic                  timeout_q
);
	logic [PS_W-1:0] ps_limit;
	logic            tick;

	// prescaler wraps after 2^ps_sel clocks
	assign ps_limit = PS_W'((1 << ps_sel) - 1);
	assign tick     = enable && (prescale_q == ps_limit);

	// prescaler; a refresh resets it ahead of everything else
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_q <= '0;
		end else if (clear) begin
			prescale_q <= '0;
		end else if (tick) begin
			prescale_q <= '0;
		end else if (enable) begin
			prescale_q <= prescale_q + PS_W'(1);
		end
	end

	// main counter; overflow gives a one-cycle timeout pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q   <= '0;
			timeout_q <= 1'b0;
		end else if (clear) begin
			count_q   <= '0;
			timeout_q <= 1'b0;
		end else begin
			timeout_q <= tick && (&count_q);
			if (tick) begin
				count_q <= count_q + CNT_W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/cie_core_model.sv ----
// far-side core model: fetch aligned to phase Q1 and a 128-byte register file
`default_nettype none
module cie_core_model (
	input  wire logic                pclk,
	input  wire cie_pkg::cie_phase_e phase,
	output logic [13:0]              instr_word,
	output logic                     instr_valid,
	input  wire logic                file_we,
	input  wire logic [6:0]          file_addr,
	input  wire logic [7:0]          file_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] regs [128];

	// nonzero preload so that a clear is visible
	initial begin
		for (int i = 0; i < 128; i++) begin
			regs[i] = 8'hA5 ^ 8'(i);
		end
		instr_word = 14'h3FFF;
		instr_valid = 1'b0;
	end

	// register file write port, taken at the edge that ends Q4
	always @(posedge pclk) begin
		if (file_we) begin
			regs[file_addr] <= file_wdata;
		end
	end

	// one word per instruction cycle, offered only while phase is Q1
	task automatic issue(input logic [13:0] w, input logic v);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (phase !== cie_pkg::CIE_Q4 && n < 8);
		instr_word <= w;
		instr_valid <= v;
		@(posedge pclk);
		instr_word <= ~w; // released word shows the inverse, never a stale copy
		instr_valid <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- testbench/cie_clear_exec_tb.sv ----
// self-checking bench of the clear-instruction executor
`default_nettype none
module cie_clear_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, rd, cw;
	logic [3:0]          pstrb;
	logic [13:0]         instr_word;
	logic                instr_valid, sleep_entry, file_we, zero_flag, er;
	logic                timeout_flag_n, powerdown_flag_n, watchdog_timeout;
	cie_pkg::cie_phase_e phase;
	logic [6:0]          file_addr, a;
	logic [7:0]          file_wdata, working_register;
	logic [1:0]          watchdog_counter, watchdog_prescale;
	int                  err_count, n_tests;

	// small counters so the watchdog times out within a few dozen cycles
	cie_clear_exec #(.WDOG_W(2), .PS_W(2)) cie_clear_exec_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_word(instr_word), .instr_valid(instr_valid),
		.sleep_entry(sleep_entry), .phase(phase), .file_we(file_we), .file_addr(file_addr),
		.file_wdata(file_wdata), .working_register(working_register), .zero_flag(zero_flag),
		.timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
		.watchdog_counter(watchdog_counter), .watchdog_prescale(watchdog_prescale),
		.watchdog_timeout(watchdog_timeout)
	);

	cie_core_model cm_i (
		.pclk(pclk), .phase(phase), .instr_word(instr_word), .instr_valid(instr_valid),
		.file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata)
	);

	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// status word expected from the three flags
	function automatic logic [31:0] exp_status(input logic z, input logic pd, input logic to);
		return {29'h0, to, pd, z};
	endfunction

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= ad;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			report_and_stop();
		end
	endtask

	// bounded wait for the timeout flag to reach a level
	task automatic wait_to(input logic lvl);
		int n;
		n = 0;
		while (timeout_flag_n !== lvl && n < 500) begin
			@(posedge pclk);
			n++;
		end
		if (timeout_flag_n !== lvl) begin
			err_count++;
			report_and_stop();
		end
	endtask

	// issue one word and follow its four phases; returns one cycle after Q4
	task automatic run_op(input logic [13:0] w, input logic v, input logic we);
		logic z;
		cm_i.issue(w, v);
		z = zero_flag;
		@(posedge pclk);
		#1;
		chk("phase in Q3", phase, cie_pkg::CIE_Q3);
		chk("write in Q3", file_we, 1'b0);
		@(posedge pclk);
		#1;
		chk("write in Q4", file_we, we);
		chk("zero flag before end", zero_flag, z);
		if (we) chk("file address", file_addr, w[6:0]);
		@(posedge pclk);
		#1;
	endtask

	// main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		sleep_entry = 1'b0;
		presetn = 1'b0;
		err_count = 0;
		n_tests = 0;
		void'($urandom(5932));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0);
		chk("status at reset", rd & 32'h7, exp_status(1'b0, 1'b1, 1'b1));
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped error", er, 1'b1);
		chk("unmapped read zero", rd, 32'h0);
		$display("test reset done");
		// watchdog running, timed out, asleep, then refreshed
		cw = 32'h0000_0001 | (32'($urandom_range(1, 2)) << 1);
		apb(1'b1, cie_pkg::ADDR_CTRL, cw);
		apb(1'b0, cie_pkg::ADDR_CTRL, 32'h0);
		chk("control readback", rd, cw);
		wait_to(1'b0);
		sleep_entry <= 1'b1;
		@(posedge pclk);
		sleep_entry <= 1'b0;
		@(posedge pclk);
		#1;
		chk("asleep", powerdown_flag_n, 1'b0);
		run_op(14'h0065, 1'b1, 1'b0);
		chk("lookalike ignored", timeout_flag_n, 1'b0);
		run_op(cie_pkg::OPC_WDOG_REFRESH, 1'b0, 1'b0);
		chk("invalid ignored", timeout_flag_n, 1'b0);
		run_op(cie_pkg::OPC_WDOG_REFRESH, 1'b1, 1'b0);
		chk("counter cleared", watchdog_counter, 2'h0);
		chk("prescale cleared", watchdog_prescale, 2'h0);
		chk("timeout pulse cleared", watchdog_timeout, 1'b0);
		chk("timeout flag", timeout_flag_n, 1'b1);
		chk("powerdown flag", powerdown_flag_n, 1'b1);
		chk("zero flag kept", zero_flag, 1'b0);
		$display("test refresh done");
		// accumulator clear with random ignored bits
		run_op({cie_pkg::OPC_CLEAR_ACC, 7'($urandom)}, 1'b1, 1'b0);
		chk("accumulator", working_register, 8'h00);
		chk("zero after acc", zero_flag, 1'b1);
		$display("test accumulator done");
		// second reset in mid-run brings the zero flag back down; one edge first, with
		// the accumulator checks already done before that edge and before reset
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("zero after reset", zero_flag, 1'b0);
		// file clears at both ends of the range and at random addresses
		for (int i = 0; i < 12; i++) begin
			a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom_range(0, 127));
			run_op({cie_pkg::OPC_CLEAR_FILE, a}, 1'b1, 1'b1);
			chk("file cleared", cm_i.regs[a], 8'h00);
			chk("zero after file", zero_flag, 1'b1);
		end
		// control write without its byte strobe is ignored
		pstrb <= 4'h0;
		apb(1'b1, cie_pkg::ADDR_CTRL, 32'h0000_000F);
		pstrb <= 4'hF;
		apb(1'b0, cie_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl write without strobe", rd, 32'h0);
		apb(1'b0, cie_pkg::ADDR_EXECS, 32'h0);
		chk("executed clears", rd, 32'h0000_000C);
		apb(1'b0, cie_pkg::ADDR_STATUS, 32'h0);
		chk("status at end", rd & 32'h7, exp_status(1'b1, 1'b1, 1'b1));
		$display("test file clear done");
		report_and_stop();
	end
endmodule
`default_nettype wire
